/* File: hw/mmvs_consts.svh */
`ifndef MMVS_CONSTS_SVH
`define MMVS_CONSTS_SVH

// ***************************************************************
// program space map
// ***************************************************************
`define MMVS_PROG_KB      16'd32        // implemented program memory size: 4, 8, 16, 24 or 32
`define MMVS_KB_SHIFT     10            // kilobytes to bytes
`define MMVS_RESET_VEC    16'hFFFE      // low byte of the reset vector
`define MMVS_PAGE_HI      8'hFF         // high byte of every page-call target
`define MMVS_TABLE_BASE   16'hFFDE      // entry 0, higher entries sit lower
`define MMVS_IRQ_BASE     16'hFFE0      // interrupt vector n at base + 2n

// ***************************************************************
// data space map
// ***************************************************************
`define MMVS_CTRL_LO      9'h0C0        // first control register
`define MMVS_CTRL_HI      9'h0FF        // last control register
`define MMVS_STACK_PAGE   1'b1          // stack lives in page 100..1FF

// ***************************************************************
// status word and reset values
// ***************************************************************
`define MMVS_PSW_BRK_BIT  4             // break flag position in the status word
`define MMVS_PC_RST       16'h0000
`define MMVS_SP_RST       8'h00         // not a promise: software loads it
`define MMVS_PSW_RST      8'h00
`define MMVS_BYTE_RST     8'h00

`endif

/* File: hw/mmvs_core.sv */
// How it works
// - 16-bit program counter wraps past top address
// - only top 4..32K of program space implemented
// - after reset, load PC from FFFE/FFFF
// - page call targets FF00..FFFF, no push shortcut
// - table call n vectors through FFDE minus 2n
// - software break shares table call zero vector
// - interrupt n vectors through FFE0 plus 2n
// - vector area readable as ordinary program memory
// - 448 bytes of user ram incl. stack
// - data 0C0..0FF goes to control registers
// - unused control addresses simply passed through
// - push return address before jumping to target
// - subroutine return pops PC; interrupt return adds flags
// - stack pointer post-decrement push, pre-increment pop
// - stack in page 100..1FF, software loads pointer
// - software break sets break flag in pushed status
`timescale 1ns/10ps
`default_nettype none
`include "mmvs_consts.svh"

module mmvs_core
   import mmvs_pkg::*;
(
   input  wire logic        i_mclk,        // system clock, 10 MHz
   input  wire logic        i_rst_b,       // synchronous reset, active low
   input  wire mmvs_cmd_t   i_cmd,         // command from the core, taken when idle
   input  wire mmvs_dacc_t  i_dacc,        // plain data access, taken when idle and no command
   input  wire logic [7:0]  i_pmem_rdata,  // program memory data, one cycle after strobe
   input  wire logic [7:0]  i_dmem_rdata,  // ram data, one cycle after strobe
   input  wire logic [7:0]  i_creg_rdata,  // control register data, one cycle after strobe
   output mmvs_preq_t       o_pmem,        // program memory request
   output mmvs_dreq_t       o_dmem,        // data memory / control register request
   output logic [15:0]      o_pc,          // program counter
   output logic [7:0]       o_sp,          // stack pointer
   output logic [7:0]       o_psw,         // restored status word
   output logic             o_psw_ld,      // pulse: take o_psw
   output logic [7:0]       o_rdata,       // fetched or read byte
   output logic             o_rdata_vld,   // pulse: o_rdata valid
   output logic             o_done,        // pulse: command finished
   output logic             o_busy         // level: commands are refused
);

   // ***************************************************************
   // state and decode
   // ***************************************************************
   mmvs_core_t cur_reg;
   mmvs_core_t raw_next;
   mmvs_core_t cur_next;
   logic       prog_hit;
   logic       ram_sel;
   logic       ctrl_sel;

   // decode works on the next bus addresses so the select flops line up with them
   mmvs_map_decode u_decode (
      .i_prog_addr (raw_next.pmem.addr),
      .i_data_addr (raw_next.dmem.addr),
      .o_prog_hit  (prog_hit),
      .o_ram_sel   (ram_sel),
      .o_ctrl_sel  (ctrl_sel)
   );

   // ***************************************************************
   // sequencer
   // ***************************************************************
   // every bus word is prepared one state ahead, so memory sees it from a flop
   always_comb begin
      logic [1:0]  need;
      logic [1:0]  pos;
      logic [1:0]  owed;
      raw_next           = cur_reg;
      raw_next.pmem.rd   = 1'b0;
      raw_next.dmem.rd   = 1'b0;
      raw_next.dmem.wr   = 1'b0;
      raw_next.psw_ld    = 1'b0;
      raw_next.rdata_vld = 1'b0;
      raw_next.done      = 1'b0;
      need               = cur_reg.with_psw ? 2'd3 : 2'd2;
      pos                = 2'(cur_reg.captured + (cur_reg.with_psw ? 2'd0 : 2'd1));
      owed               = 2'(cur_reg.issued - cur_reg.captured);
      unique case (cur_reg.st)
         MMVS_ST_RST: begin
            raw_next.vec       = `MMVS_RESET_VEC;
            raw_next.pmem.rd   = 1'b1;
            raw_next.pmem.addr = `MMVS_RESET_VEC;
            raw_next.st        = MMVS_ST_VEC_LO;
         end
         MMVS_ST_IDLE: begin
            raw_next.with_psw = 1'b0;
            raw_next.direct   = 1'b0;
            raw_next.issued   = 2'd0;
            raw_next.captured = 2'd0;
            raw_next.psw_buf  = i_cmd.psw;
            if (i_cmd.valid) begin
               unique case (i_cmd.op)
                  MMVS_OP_FETCH, MMVS_OP_PROG_READ: begin
                     raw_next.pmem.rd   = 1'b1;
                     raw_next.pmem.addr = (i_cmd.op == MMVS_OP_FETCH) ? cur_reg.pc : i_cmd.target;
                     if (i_cmd.op == MMVS_OP_FETCH) begin
                        raw_next.pc = 16'(cur_reg.pc + 16'h0001);
                     end
                     raw_next.st = MMVS_ST_PRD_W;
                  end
                  MMVS_OP_CALL, MMVS_OP_PAGE_CALL, MMVS_OP_TABLE_CALL,
                  MMVS_OP_SOFT_BREAK, MMVS_OP_INTERRUPT: begin
                     unique case (i_cmd.op)
                        MMVS_OP_CALL: begin
                           raw_next.vec    = i_cmd.target;
                           raw_next.direct = 1'b1;
                        end
                        MMVS_OP_PAGE_CALL: begin
                           raw_next.vec    = {`MMVS_PAGE_HI, i_cmd.operand};
                           raw_next.direct = 1'b1;
                        end
                        MMVS_OP_TABLE_CALL: begin
                           raw_next.vec = 16'(`MMVS_TABLE_BASE - {11'h000, i_cmd.operand[3:0], 1'b0});
                        end
                        MMVS_OP_SOFT_BREAK: begin
                           raw_next.vec      = `MMVS_TABLE_BASE;
                           raw_next.with_psw = 1'b1;
                           raw_next.psw_buf[`MMVS_PSW_BRK_BIT] = 1'b1;
                        end
                        default: begin
                           raw_next.vec      = 16'(`MMVS_IRQ_BASE + {11'h000, i_cmd.operand[3:0], 1'b0});
                           raw_next.with_psw = 1'b1;
                        end
                     endcase
                     // return address goes out high byte first, before any jump
                     raw_next.dmem.wr    = 1'b1;
                     raw_next.dmem.addr  = {`MMVS_STACK_PAGE, cur_reg.sp};
                     raw_next.dmem.wdata = cur_reg.pc[15:8];
                     raw_next.sp         = 8'(cur_reg.sp - 8'h01);
                     raw_next.st         = MMVS_ST_PUSH_LO;
                  end
                  MMVS_OP_SUB_RETURN, MMVS_OP_INT_RETURN: begin
                     raw_next.with_psw = (i_cmd.op == MMVS_OP_INT_RETURN);
                     raw_next.st       = MMVS_ST_POP;
                  end
                  MMVS_OP_SP_LOAD: begin
                     raw_next.sp   = i_cmd.operand;
                     raw_next.done = 1'b1;
                  end
                  MMVS_OP_PC_LOAD: begin
                     raw_next.pc   = i_cmd.target;
                     raw_next.done = 1'b1;
                  end
                  default: begin
                     raw_next.done = 1'b1;
                  end
               endcase
            end else if (i_dacc.rd || i_dacc.wr) begin
               // unused control addresses are passed on as they are
               raw_next.dmem.rd    = i_dacc.rd;
               raw_next.dmem.wr    = i_dacc.wr && !i_dacc.rd;
               raw_next.dmem.addr  = i_dacc.addr;
               raw_next.dmem.wdata = i_dacc.wdata;
               raw_next.st         = MMVS_ST_DATA_W;
            end
         end
         MMVS_ST_PUSH_LO: begin
            raw_next.dmem.wr    = 1'b1;
            raw_next.dmem.addr  = {`MMVS_STACK_PAGE, cur_reg.sp};
            raw_next.dmem.wdata = cur_reg.pc[7:0];
            raw_next.sp         = 8'(cur_reg.sp - 8'h01);
            raw_next.st         = cur_reg.with_psw ? MMVS_ST_PUSH_PSW : MMVS_ST_PUSH_END;
         end
         MMVS_ST_PUSH_PSW: begin
            raw_next.dmem.wr    = 1'b1;
            raw_next.dmem.addr  = {`MMVS_STACK_PAGE, cur_reg.sp};
            raw_next.dmem.wdata = cur_reg.psw_buf;
            raw_next.sp         = 8'(cur_reg.sp - 8'h01);
            raw_next.st         = MMVS_ST_PUSH_END;
         end
         MMVS_ST_PUSH_END: begin
            if (cur_reg.direct) begin
               raw_next.pc   = cur_reg.vec;
               raw_next.done = 1'b1;
               raw_next.st   = MMVS_ST_IDLE;
            end else begin
               raw_next.pmem.rd   = 1'b1;
               raw_next.pmem.addr = cur_reg.vec;
               raw_next.st        = MMVS_ST_VEC_LO;
            end
         end
         MMVS_ST_VEC_LO: begin
            raw_next.pmem.rd   = 1'b1;
            raw_next.pmem.addr = 16'(cur_reg.vec + 16'h0001);
            raw_next.st        = MMVS_ST_VEC_HI;
         end
         MMVS_ST_VEC_HI: begin
            raw_next.vec[7:0] = i_pmem_rdata;
            raw_next.st       = MMVS_ST_VEC_END;
         end
         MMVS_ST_VEC_END: begin
            raw_next.pc   = {i_pmem_rdata, cur_reg.vec[7:0]};
            raw_next.done = 1'b1;
            raw_next.st   = MMVS_ST_IDLE;
         end
         MMVS_ST_POP: begin
            // reads overlap captures: pointer moves up before each read
            if (cur_reg.issued != need) begin
               raw_next.dmem.rd   = 1'b1;
               raw_next.dmem.addr = {`MMVS_STACK_PAGE, 8'(cur_reg.sp + 8'h01)};
               raw_next.sp        = 8'(cur_reg.sp + 8'h01);
               raw_next.issued    = 2'(cur_reg.issued + 2'd1);
            end
            // data trails its strobe by one cycle
            if (owed == 2'd2 || (owed == 2'd1 && !cur_reg.dmem.rd)) begin
               raw_next.captured = 2'(cur_reg.captured + 2'd1);
               unique case (pos)
                  2'd0: raw_next.psw_buf  = i_dmem_rdata;
                  2'd1: raw_next.vec[7:0] = i_dmem_rdata;
                  default: begin
                     raw_next.pc      = {i_dmem_rdata, cur_reg.vec[7:0]};
                     raw_next.psw_out = cur_reg.psw_buf;
                     raw_next.psw_ld  = cur_reg.with_psw;
                     raw_next.done    = 1'b1;
                     raw_next.st      = MMVS_ST_IDLE;
                  end
               endcase
            end
         end
         MMVS_ST_PRD_W: begin
            raw_next.st = MMVS_ST_PRD_D;
         end
         MMVS_ST_PRD_D: begin
            raw_next.rdata     = i_pmem_rdata;
            raw_next.rdata_vld = 1'b1;
            raw_next.done      = 1'b1;
            raw_next.st        = MMVS_ST_IDLE;
         end
         MMVS_ST_DATA_W: begin
            raw_next.rd_ctrl = cur_reg.dmem.ctrl_sel;
            if (cur_reg.dmem.rd) begin
               raw_next.st = MMVS_ST_DATA_D;
            end else begin
               raw_next.done = 1'b1;
               raw_next.st   = MMVS_ST_IDLE;
            end
         end
         MMVS_ST_DATA_D: begin
            raw_next.rdata     = cur_reg.rd_ctrl ? i_creg_rdata : i_dmem_rdata;
            raw_next.rdata_vld = 1'b1;
            raw_next.done      = 1'b1;
            raw_next.st        = MMVS_ST_IDLE;
         end
         default: begin
            raw_next.st = MMVS_ST_IDLE;
         end
      endcase
      raw_next.busy = (raw_next.st != MMVS_ST_IDLE);
   end

   // selects are folded in after the decoder to keep the sequencer free of loops
   always_comb begin
      cur_next               = raw_next;
      cur_next.pmem.hit      = prog_hit;
      cur_next.dmem.ram_sel  = ram_sel;
      cur_next.dmem.ctrl_sel = ctrl_sel;
   end

   // ***************************************************************
   // registers
   // ***************************************************************
   always_ff @(posedge i_mclk) begin
      if (!i_rst_b) begin
         cur_reg          <= '0;
         cur_reg.st       <= MMVS_ST_RST;
         cur_reg.pc       <= `MMVS_PC_RST;
         cur_reg.sp       <= `MMVS_SP_RST;
         cur_reg.psw_out  <= `MMVS_PSW_RST;
         cur_reg.rdata    <= `MMVS_BYTE_RST;
         cur_reg.busy     <= 1'b1;
      end else begin
         cur_reg <= cur_next;
      end
   end

   // ***************************************************************
   // outputs
   // ***************************************************************
   assign o_pmem      = cur_reg.pmem;
   assign o_dmem      = cur_reg.dmem;
   assign o_pc        = cur_reg.pc;
   assign o_sp        = cur_reg.sp;
   assign o_psw       = cur_reg.psw_out;
   assign o_psw_ld    = cur_reg.psw_ld;
   assign o_rdata     = cur_reg.rdata;
   assign o_rdata_vld = cur_reg.rdata_vld;
   assign o_done      = cur_reg.done;
   assign o_busy      = cur_reg.busy;

endmodule
`default_nettype wire

/* File: hw/mmvs_map_decode.sv */
`timescale 1ns/10ps
`default_nettype none
`include "mmvs_consts.svh"

module mmvs_map_decode
   import mmvs_pkg::*;
(
   input  wire logic [15:0] i_prog_addr,   // program address
   input  wire logic [8:0]  i_data_addr,   // data address
   output logic             o_prog_hit,    // address lies in implemented memory
   output logic             o_ram_sel,     // user ram or stack
   output logic             o_ctrl_sel     // control register window
);

   // ***************************************************************
   // address decode
   // ***************************************************************
   logic [15:0] prog_base;

   // implemented memory is the top slice of the space; 0 minus size wraps onto its base
   assign prog_base  = 16'(16'h0000 - (`MMVS_PROG_KB << `MMVS_KB_SHIFT));
   assign o_prog_hit = (i_prog_addr >= prog_base);
   // control window punches a hole in the 512-byte page pair, leaving 448 bytes of ram
   assign o_ctrl_sel = (i_data_addr >= `MMVS_CTRL_LO) && (i_data_addr <= `MMVS_CTRL_HI);
   assign o_ram_sel  = !o_ctrl_sel;

endmodule
`default_nettype wire

/* File: hw/mmvs_pkg.sv */
package mmvs_pkg;

   // ***************************************************************
   // commands from the core
   // ***************************************************************
   typedef enum logic [3:0] {
      MMVS_OP_NONE       = 4'h0,
      MMVS_OP_FETCH      = 4'h1,
      MMVS_OP_CALL       = 4'h2,
      MMVS_OP_PAGE_CALL  = 4'h3,
      MMVS_OP_TABLE_CALL = 4'h4,
      MMVS_OP_SOFT_BREAK = 4'h5,
      MMVS_OP_INTERRUPT  = 4'h6,
      MMVS_OP_SUB_RETURN = 4'h7,
      MMVS_OP_INT_RETURN = 4'h8,
      MMVS_OP_SP_LOAD    = 4'h9,
      MMVS_OP_PC_LOAD    = 4'hA,
      MMVS_OP_PROG_READ  = 4'hB
   } mmvs_op_t;

   typedef enum logic [3:0] {
      MMVS_ST_RST      = 4'h0,
      MMVS_ST_IDLE     = 4'h1,
      MMVS_ST_PUSH_LO  = 4'h2,
      MMVS_ST_PUSH_PSW = 4'h3,
      MMVS_ST_PUSH_END = 4'h4,
      MMVS_ST_VEC_LO   = 4'h5,
      MMVS_ST_VEC_HI   = 4'h6,
      MMVS_ST_VEC_END  = 4'h7,
      MMVS_ST_POP      = 4'h8,
      MMVS_ST_PRD_W    = 4'h9,
      MMVS_ST_PRD_D    = 4'hA,
      MMVS_ST_DATA_W   = 4'hB,
      MMVS_ST_DATA_D   = 4'hC
   } mmvs_state_t;

   typedef struct packed {
      logic        valid;
      mmvs_op_t    op;
      logic [7:0]  operand;
      logic [15:0] target;
      logic [7:0]  psw;
   } mmvs_cmd_t;

   typedef struct packed {
      logic        rd;
      logic        wr;
      logic [8:0]  addr;
      logic [7:0]  wdata;
   } mmvs_dacc_t;

   typedef struct packed {
      logic        rd;
      logic [15:0] addr;
      logic        hit;
   } mmvs_preq_t;

   typedef struct packed {
      logic        rd;
      logic        wr;
      logic [8:0]  addr;
      logic [7:0]  wdata;
      logic        ram_sel;
      logic        ctrl_sel;
   } mmvs_dreq_t;

   typedef struct packed {
      mmvs_state_t st;
      logic [15:0] pc;
      logic [7:0]  sp;
      logic [15:0] vec;
      logic [7:0]  psw_buf;
      logic        with_psw;
      logic        direct;
      logic        rd_ctrl;
      logic [1:0]  issued;
      logic [1:0]  captured;
      mmvs_preq_t  pmem;
      mmvs_dreq_t  dmem;
      logic [7:0]  psw_out;
      logic        psw_ld;
      logic [7:0]  rdata;
      logic        rdata_vld;
      logic        done;
      logic        busy;
   } mmvs_core_t;

endpackage

/* File: tb/mmvs_core_bench.sv */
`timescale 1ns/10ps
`default_nettype none

bind mmvs_core mmvs_core_props u_props (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_cmd(i_cmd), .o_busy(o_busy),
   .o_pc(o_pc), .o_sp(o_sp), .o_pmem(o_pmem), .o_dmem(o_dmem), .o_done(o_done), .o_psw_ld(o_psw_ld));

module mmvs_core_bench
   import mmvs_pkg::*;
;
   logic        i_mclk = 1'b0;
   logic        i_rst_b = 1'b0;
   mmvs_cmd_t   cmd = '0;
   mmvs_dacc_t  dacc = '0;
   logic [7:0]  prd, drd, crd, sp, psw, rdata, sp_m;
   mmvs_preq_t  pmem;
   mmvs_dreq_t  dmem;
   logic [15:0] pc, pc_m;
   logic        psw_ld, rvld, done, busy;
   logic [7:0]  mem_m [0:511] = '{default: 8'h00};
   int          bad_count = 0, n_tests = 0, seed = 1360;

   mmvs_core DUT (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_cmd(cmd), .i_dacc(dacc), .i_pmem_rdata(prd),
      .i_dmem_rdata(drd), .i_creg_rdata(crd), .o_pmem(pmem), .o_dmem(dmem), .o_pc(pc), .o_sp(sp),
      .o_psw(psw), .o_psw_ld(psw_ld), .o_rdata(rdata), .o_rdata_vld(rvld), .o_done(done), .o_busy(busy));
   mmvs_mem_model u_part (.i_mclk(i_mclk), .i_pmem(pmem), .i_dmem(dmem), .o_prd(prd), .o_drd(drd), .o_crd(crd));

   // ***************************************************************
   // reference model and bus tasks
   // ***************************************************************
   function automatic logic [7:0] pb(input logic [15:0] a);
      return a[7:0] ^ a[15:8] ^ 8'hA5;
   endfunction
   function automatic logic [15:0] vw(input logic [15:0] v);
      return {pb(v + 16'h0001), pb(v)};
   endfunction
   function automatic mmvs_cmd_t mk(input mmvs_op_t op, input logic [7:0] n, input logic [15:0] t, input logic [7:0] p);
      return '{1'b1, op, n, t, p};
   endfunction
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic push(input logic [7:0] b);
      mem_m[{1'b1, sp_m}] = b;
      sp_m = sp_m - 8'h01;
   endtask
   task automatic pop(output logic [7:0] b);
      sp_m = sp_m + 8'h01;
      b = mem_m[{1'b1, sp_m}];
   endtask
   // request held from just after one edge through the taking edge, then a bounded wait for done
   task automatic run(input mmvs_cmd_t c, input mmvs_dacc_t d);
      int k;
      @(posedge i_mclk);
      #1;
      cmd = c;
      dacc = d;
      @(posedge i_mclk);
      #1;
      cmd.valid = 1'b0;
      dacc = '0;
      for (k = 0; k < 20 && done !== 1'b1; k++) begin
         @(posedge i_mclk);
         #1;
      end
      check("done", {15'h0000, done}, 16'h0001);
      check("busy", {15'h0000, busy}, 16'h0000);
      check("pc", pc, pc_m);
      check("sp", {8'h00, sp}, {8'h00, sp_m});
   endtask
   task automatic call_m(input mmvs_cmd_t c, input logic [15:0] dest, input logic [7:0] p, input logic flag);
      push(pc_m[15:8]);
      push(pc_m[7:0]);
      if (flag) begin
         push((c.op == MMVS_OP_SOFT_BREAK) ? p | 8'h10 : p);
      end
      pc_m = dest;
      run(c, '0);
   endtask
   task automatic ret_m(input logic irq);
      logic [7:0] p, l, h;
      p = 8'h00;
      if (irq) begin
         pop(p);
      end
      pop(l);
      pop(h);
      pc_m = {h, l};
      run(mk(irq ? MMVS_OP_INT_RETURN : MMVS_OP_SUB_RETURN, 8'h00, 16'h0000, 8'h00), '0);
      if (irq) begin
         check("psw", {8'h00, psw}, {8'h00, p});
         check("psw_ld", {15'h0000, psw_ld}, 16'h0001);
      end
   endtask

   initial begin
      forever #50 i_mclk = ~i_mclk;
   end
   initial begin
      #500000;
      bad_count++;
      finish_test();
   end

   // ***************************************************************
   // scenarios
   // ***************************************************************
   initial begin
      logic [7:0]  p, d8;
      logic [8:0]  a;
      logic [15:0] t;
      int          i;
      repeat (3) @(posedge i_mclk);
      #1;
      i_rst_b = 1'b1;
      for (i = 0; i < 10 && busy !== 1'b0; i++) begin
         @(posedge i_mclk);
         #1;
      end
      pc_m = vw(16'hFFFE);
      check("reset pc", pc, pc_m);
      sp_m = 8'hFF;
      run(mk(MMVS_OP_SP_LOAD, 8'hFF, 16'h00FF, 8'h00), '0);
      pc_m = 16'hFFFF;
      run(mk(MMVS_OP_PC_LOAD, 8'h00, 16'hFFFF, 8'h00), '0);
      pc_m = 16'h0000;
      run(mk(MMVS_OP_FETCH, 8'h00, 16'h0000, 8'h00), '0);
      check("fetch top", {8'h00, rdata}, {8'h00, pb(16'hFFFF)});
      pc_m = 16'h0001;
      run(mk(MMVS_OP_FETCH, 8'h00, 16'h0000, 8'h00), '0);
      check("hit low", {15'h0000, pmem.hit}, 16'h0000);
      run(mk(MMVS_OP_PROG_READ, 8'h00, 16'hFFFA, 8'h00), '0);
      check("vector read", {8'h00, rdata}, {8'h00, pb(16'hFFFA)});
      t = $random(seed);
      call_m(mk(MMVS_OP_CALL, 8'h00, t, 8'h00), t, 8'h00, 1'b0);
      ret_m(1'b0);
      d8 = $random(seed);
      d8 = d8 % 8'hC0;
      call_m(mk(MMVS_OP_PAGE_CALL, d8, 16'h0000, 8'h00), {8'hFF, d8}, 8'h00, 1'b0);
      ret_m(1'b0);
      for (i = 0; i < 16; i++) begin
         call_m(mk(MMVS_OP_TABLE_CALL, 8'(i), 16'h0000, 8'h00), vw(16'hFFDE - 16'(2 * i)), 8'h00, 1'b0);
         ret_m(1'b0);
      end
      p = $random(seed);
      call_m(mk(MMVS_OP_SOFT_BREAK, 8'h00, 16'h0000, p), vw(16'hFFDE), p, 1'b1);
      ret_m(1'b1);
      for (i = 0; i < 15; i++) begin
         p = $random(seed);
         call_m(mk(MMVS_OP_INTERRUPT, 8'(i), 16'h0000, p), vw(16'hFFE0 + 16'(2 * i)), p, 1'b1);
         ret_m(1'b1);
      end
      for (i = 0; i < 12; i++) begin
         a = $random(seed);
         d8 = $random(seed);
         if (i % 2 == 0) begin
            a = {3'b011, a[5:0]};
         end
         mem_m[a] = d8;
         run('0, '{1'b0, 1'b1, a, d8});
         run('0, '{1'b1, 1'b0, a, 8'h00});
         t = {8'h00, (a inside {[9'h0C0:9'h0FF]}) ? d8 ^ 8'h3C : d8};
         check("data read", {8'h00, rdata}, t);
         check("read valid", {15'h0000, rvld}, 16'h0001);
      end
      finish_test();
   end
endmodule

`default_nettype wire

/* File: tb/mmvs_core_props.sv */
`timescale 1ns/10ps
`default_nettype none

module mmvs_core_props
   import mmvs_pkg::*;
(
   input  wire logic        i_mclk,    // system clock
   input  wire logic        i_rst_b,   // sync reset, active low
   input  wire mmvs_cmd_t   i_cmd,     // command from the core
   input  wire logic        o_busy,    // commands refused
   input  wire logic [15:0] o_pc,      // program counter
   input  wire logic [7:0]  o_sp,      // stack pointer
   input  wire mmvs_preq_t  o_pmem,    // program request
   input  wire mmvs_dreq_t  o_dmem,    // data request
   input  wire logic        o_done,    // finish pulse
   input  wire logic        o_psw_ld   // status restore pulse
);
   // ***************************************************************
   // helper logic
   // ***************************************************************
   logic        take;
   logic [15:0] vec_reg;
   assign take = !o_busy && i_cmd.valid;
   // vector expected for the command just taken; held so ranges can look back at it
   always_ff @(posedge i_mclk) begin
      if (take) begin
         vec_reg <= (i_cmd.op == MMVS_OP_INTERRUPT) ? 16'hFFE0 + {11'h000, i_cmd.operand[3:0], 1'b0} :
                    (i_cmd.op == MMVS_OP_SOFT_BREAK) ? 16'hFFDE : 16'hFFDE - {11'h000, i_cmd.operand[3:0], 1'b0};
      end
   end
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_rst_b);
   // ***************************************************************
   // properties
   // ***************************************************************
   fetch_wrap_a: assert property (take && i_cmd.op == MMVS_OP_FETCH |=>
      o_pmem.rd && o_pmem.addr == $past(o_pc) && o_pc == $past(o_pc) + 16'h0001)
      else $error("fetch address or counter step wrong");
   prog_hit_a: assert property (o_pmem.rd |-> o_pmem.hit == (o_pmem.addr >= 16'h8000))
      else $error("program hit flag wrong");
   reset_vec_a: assert property ($rose(i_rst_b) |=>
      o_pmem.rd && o_pmem.addr == 16'hFFFE ##1 o_pmem.rd && o_pmem.addr == 16'hFFFF)
      else $error("reset vector fetch wrong");
   page_call_a: assert property (take && i_cmd.op == MMVS_OP_PAGE_CALL |->
      ##3 o_done && o_pc == {8'hFF, $past(i_cmd.operand, 3)})
      else $error("page call target wrong");
   table_vec_a: assert property (take && i_cmd.op == MMVS_OP_TABLE_CALL |->
      ##[2:8] (o_pmem.rd && o_pmem.addr == vec_reg))
      else $error("table vector not read");
   break_vec_a: assert property (take && i_cmd.op == MMVS_OP_SOFT_BREAK |->
      ##[2:8] (o_pmem.rd && o_pmem.addr == vec_reg))
      else $error("break vector not read");
   irq_vec_a: assert property (take && i_cmd.op == MMVS_OP_INTERRUPT |->
      ##[2:8] (o_pmem.rd && o_pmem.addr == vec_reg))
      else $error("interrupt vector not read");
   ctrl_window_a: assert property ((o_dmem.rd || o_dmem.wr) |->
      o_dmem.ctrl_sel == (o_dmem.addr inside {[9'h0C0:9'h0FF]}) && o_dmem.ram_sel == !o_dmem.ctrl_sel)
      else $error("data select wrong");
   push_order_a: assert property (take && i_cmd.op == MMVS_OP_CALL |=>
      o_dmem.wr && o_dmem.addr == {1'b1, $past(o_sp)} && o_dmem.wdata == $past(o_pc[15:8])
      ##1 o_dmem.wr && o_dmem.addr == {1'b1, $past(o_sp, 2) - 8'h01} && o_dmem.wdata == $past(o_pc[7:0], 2))
      else $error("return address push wrong");
   break_flag_a: assert property (take && i_cmd.op == MMVS_OP_SOFT_BREAK |-> ##3 o_dmem.wr && o_dmem.wdata[4])
      else $error("break flag not pushed");
   int_return_a: assert property (take && i_cmd.op == MMVS_OP_INT_RETURN |-> ##6 o_done && o_psw_ld)
      else $error("status not restored");
   cover property (take && i_cmd.op == MMVS_OP_INTERRUPT);
   cover property (o_psw_ld);
   cover property (o_dmem.rd && o_dmem.ctrl_sel);
endmodule

`default_nettype wire

/* File: tb/mmvs_mem_model.sv */
`timescale 1ns/10ps
`default_nettype none

module mmvs_mem_model
   import mmvs_pkg::*;
(
   input  wire logic       i_mclk,         // system clock
   input  wire mmvs_preq_t i_pmem,         // program request
   input  wire mmvs_dreq_t i_dmem,         // data request
   output logic [7:0]      o_prd = 8'h00,  // program byte
   output logic [7:0]      o_drd = 8'h00,  // ram byte
   output logic [7:0]      o_crd = 8'h00   // control register byte
);
   logic [7:0] ram [0:511] = '{default: 8'h00};
   function automatic logic [7:0] pb(input logic [15:0] a);
      return a[7:0] ^ a[15:8] ^ 8'hA5;
   endfunction
   // answers one cycle after the strobe; idle lines toggle so stale data never looks valid
   always @(posedge i_mclk) begin
      o_prd <= i_pmem.rd ? pb(i_pmem.addr) : ~o_prd;
      o_drd <= (i_dmem.rd && i_dmem.ram_sel) ? ram[i_dmem.addr] : ~o_drd;
      o_crd <= (i_dmem.rd && i_dmem.ctrl_sel) ? ram[i_dmem.addr] ^ 8'h3C : ~o_crd;
      if (i_dmem.wr) begin
         ram[i_dmem.addr] <= i_dmem.wdata;
      end
   end
endmodule

`default_nettype wire
